/* core/led_matrix_intensity_plane_control.sv */
// Notes on behaviour
// - Panel code scales drive in 254 steps, 255/256 down to 2/256.
// - Each digit duty is n/256 of the panel duty value.
// - At least 4/256 of each digit period stays blanked.
// - Depth bit D7 selects four 1-bit planes or two 2-bit planes.
// - Without four-level support the depth bit stays zero, writes dropped.
// - Two-bit levels: arithmetic off,1/3,2/3,full; geometric off,1/4,1/2,full.
// - Each digit keeps its own graduation choice.
// - Driver select is an 8-bit register at 0x08.
// - 14-bit memory pointer: low byte 0x09, bits 13-8 at 0x0a.
// - At 0x0b D6 auto, D7 fast; manual picks plane from low bits.
// - Auto slow advances one plane every N seconds.
// - Auto fast advances N planes per second.
// - Panel brightness is an 8-bit register at 0x02.
// - Auto starts at plane zero, wraps over available planes until rewritten.
// - Pointer increments after every data byte, wrapping to zero.
// - Host loads driver select first; it picks who answers a read.
`timescale 1ns/10ps
`default_nettype none
`include "led_cfg.svh"
module led_matrix_intensity_plane_control
	import led_pkg::*;
#(
	parameter int unsigned CYCLES_PER_SECOND = `CYCLES_PER_SECOND
) (
	// Clock and reset
	input  wire logic        clk_in,
	input  wire logic        srst_in,
	// Variant strap and driver identity
	input  wire logic        four_level_in,
	input  wire logic [7:0]  driver_id_in,
	// Register write port
	input  wire logic        wr_en_in,
	input  wire logic [7:0]  wr_addr_in,
	input  wire logic [7:0]  wr_data_in,
	// Register read port
	input  wire logic        rd_en_in,
	input  wire logic [7:0]  rd_addr_in,
	output logic      [7:0]  rd_data_out,
	output logic             rd_valid_out,
	output logic             rd_mine_out,
	// Display memory data transfer
	input  wire logic        data_xfer_in,
	output logic      [13:0] display_ptr_out,
	// Pixel levels from display memory
	input  wire logic [1:0]  pixel_level0_in,
	input  wire logic [1:0]  pixel_level1_in,
	// Drive outputs
	output logic             seg_drive_out,
	output logic             digit_sel_out,
	output logic      [1:0]  plane_out,
	output logic             plane_depth_out
);

	////////////////////////////////////////////////////////////////
	// Registers

	byte_t       panel_brightness;
	byte_t       digit0_intensity;
	byte_t       digit1_intensity;
	byte_t       driver_select_pointer;
	logic [13:0] display_ptr;
	byte_t       plane_sequencer_control;
	logic        plane_depth_select;
	logic [1:0]  pixel_scale;

	logic        wr_panel;
	logic        wr_dig0;
	logic        wr_dig1;
	logic        wr_drv;
	logic        wr_ptr_lo;
	logic        wr_ptr_hi;
	logic        wr_seq;
	logic        wr_cfg;
	logic        wr_scale;

	// Write decode
	assign wr_panel  = wr_en_in && (wr_addr_in == `ADDR_PANEL_BRIGHTNESS);
	assign wr_dig0   = wr_en_in && (wr_addr_in == `ADDR_DIGIT0_INTENSITY);
	assign wr_dig1   = wr_en_in && (wr_addr_in == `ADDR_DIGIT1_INTENSITY);
	assign wr_drv    = wr_en_in && (wr_addr_in == `ADDR_DRIVER_SELECT);
	assign wr_ptr_lo = wr_en_in && (wr_addr_in == `ADDR_DISPLAY_PTR_LOW);
	assign wr_ptr_hi = wr_en_in && (wr_addr_in == `ADDR_DISPLAY_PTR_HIGH);
	assign wr_seq    = wr_en_in && (wr_addr_in == `ADDR_PLANE_SEQ_CTRL);
	assign wr_cfg    = wr_en_in && (wr_addr_in == `ADDR_PANEL_CONFIG);
	assign wr_scale  = wr_en_in && (wr_addr_in == `ADDR_PIXEL_SCALE);

	// Plain byte registers
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			panel_brightness        <= `RST_BYTE;
			digit0_intensity        <= `RST_BYTE;
			digit1_intensity        <= `RST_BYTE;
			driver_select_pointer   <= `RST_BYTE;
			plane_sequencer_control <= `RST_BYTE;
			pixel_scale             <= `RST_GRAD;
		end else begin
			if (wr_panel) panel_brightness <= wr_data_in;
			if (wr_dig0) digit0_intensity <= wr_data_in;
			if (wr_dig1) digit1_intensity <= wr_data_in;
			if (wr_drv) driver_select_pointer <= wr_data_in;
			if (wr_seq) plane_sequencer_control <= wr_data_in;
			if (wr_scale) pixel_scale <= wr_data_in[1:0];
		end
	end

	// Plane depth bit, forced low on two-level variants
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			plane_depth_select <= 1'b0;
		end else if (!four_level_in) begin
			plane_depth_select <= 1'b0;
		end else if (wr_cfg) begin
			plane_depth_select <= wr_data_in[`PANEL_CFG_DEPTH_BIT];
		end
	end

	logic [13:0] next_display_ptr;

	// Pointer load or post-increment, write wins
	always_comb begin
		next_display_ptr = display_ptr;
		if (data_xfer_in) next_display_ptr = display_ptr + 14'h0001;
		if (wr_ptr_lo) next_display_ptr = {display_ptr[13:8], wr_data_in};
		if (wr_ptr_hi) next_display_ptr = {wr_data_in[`PTR_HIGH_MSB:0], display_ptr[7:0]};
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) display_ptr <= `RST_PTR;
		else display_ptr <= next_display_ptr;
	end

	////////////////////////////////////////////////////////////////
	// Register read

	byte_t read_mux;
	plane_t current_plane;

	// Read data selection, unmapped reads return zero
	always_comb begin
		unique case (rd_addr_in)
			`ADDR_PANEL_BRIGHTNESS: read_mux = panel_brightness;
			`ADDR_DIGIT0_INTENSITY: read_mux = digit0_intensity;
			`ADDR_DIGIT1_INTENSITY: read_mux = digit1_intensity;
			`ADDR_DRIVER_SELECT:    read_mux = driver_select_pointer;
			`ADDR_DISPLAY_PTR_LOW:  read_mux = display_ptr[7:0];
			`ADDR_DISPLAY_PTR_HIGH: read_mux = {2'h0, display_ptr[13:8]};
			`ADDR_PLANE_SEQ_CTRL:   read_mux = plane_sequencer_control;
			`ADDR_PANEL_CONFIG:     read_mux = {plane_depth_select, 2'h0, 1'b0, current_plane, 2'h0};
			`ADDR_PIXEL_SCALE:      read_mux = {6'h00, pixel_scale};
			default:                read_mux = 8'h00;
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			rd_data_out  <= 8'h00;
			rd_valid_out <= 1'b0;
			rd_mine_out  <= 1'b0;
		end else begin
			rd_valid_out <= rd_en_in;
			rd_mine_out  <= rd_en_in && (driver_select_pointer == driver_id_in);
			if (rd_en_in) rd_data_out <= read_mux;
		end
	end

	////////////////////////////////////////////////////////////////
	// Plane sequencer

	plane_t      next_plane;
	plane_t      last_plane;
	plane_t      manual_plane;
	seq_mode_e   seq_mode;
	logic [5:0]  seq_count;
	logic [31:0] sec_cnt;
	logic        sec_tick;
	logic [5:0]  slow_cnt;
	logic [31:0] fast_acc;
	logic [31:0] fast_sum;
	logic        fast_hit;
	logic        advance;

	// Mode decode and plane limits
	assign seq_count    = plane_sequencer_control[`SEQ_COUNT_MSB:0];
	assign seq_mode     = !plane_sequencer_control[`SEQ_AUTO_BIT] ? SEQ_MANUAL :
	                      plane_sequencer_control[`SEQ_FAST_BIT] ? SEQ_AUTO_FAST : SEQ_AUTO_SLOW;
	assign last_plane   = plane_depth_select ? 2'h1 : 2'h3;
	assign manual_plane = plane_depth_select ? {1'b0, plane_sequencer_control[0]}
	                                         : plane_sequencer_control[1:0];
	assign sec_tick     = (sec_cnt == CYCLES_PER_SECOND - 1);
	assign fast_sum     = fast_acc + {26'h0, seq_count};
	assign fast_hit     = fast_sum >= CYCLES_PER_SECOND;

	// Advance strobe per mode, zero count never advances
	always_comb begin
		unique case (seq_mode)
			SEQ_MANUAL:    advance = 1'b0;
			SEQ_AUTO_SLOW: advance = sec_tick && (seq_count != 6'h00) && (slow_cnt == seq_count - 6'h01);
			SEQ_AUTO_FAST: advance = fast_hit;
		endcase
	end

	// Second divider and slow second counter
	always_ff @(posedge clk_in) begin
		if (srst_in || wr_seq) begin
			sec_cnt  <= 32'h0000_0000;
			slow_cnt <= 6'h00;
		end else begin
			sec_cnt <= sec_tick ? 32'h0000_0000 : sec_cnt + 32'h0000_0001;
			if (advance) slow_cnt <= 6'h00;
			else if (sec_tick) slow_cnt <= slow_cnt + 6'h01;
		end
	end

	// Fast rate accumulator, N hits per second
	always_ff @(posedge clk_in) begin
		if (srst_in || wr_seq || seq_mode != SEQ_AUTO_FAST) fast_acc <= 32'h0000_0000;
		else if (fast_hit) fast_acc <= fast_sum - CYCLES_PER_SECOND;
		else fast_acc <= fast_sum;
	end

	// Current plane selection
	always_comb begin
		next_plane = current_plane;
		if (wr_seq) begin
			if (wr_data_in[`SEQ_AUTO_BIT]) next_plane = 2'h0;
			else next_plane = plane_depth_select ? {1'b0, wr_data_in[0]} : wr_data_in[1:0];
		end else if (seq_mode == SEQ_MANUAL) begin
			next_plane = manual_plane;
		end else if (current_plane > last_plane) begin
			next_plane = 2'h0;
		end else if (advance) begin
			next_plane = (current_plane == last_plane) ? 2'h0 : current_plane + 2'h1;
		end
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) current_plane <= 2'h0;
		else current_plane <= next_plane;
	end

	////////////////////////////////////////////////////////////////
	// Multiplex timing

	logic [7:0] step_div;
	logic       step_tick;
	logic [7:0] step;
	logic       digit;
	logic [3:0] frame;
	byte_t      panel_duty;

	assign step_tick = (step_div == 8'(`STEP_CYCLES - 1));

	// Step divider, 256 steps per digit period, digits alternate
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			step_div <= 8'h00;
			step     <= 8'h00;
			digit    <= 1'b0;
			frame    <= 4'h0;
		end else begin
			step_div <= step_tick ? 8'h00 : step_div + 8'h01;
			if (step_tick) step <= step + 8'h01;
			if (step_tick && step == 8'hff) begin
				digit <= ~digit;
				if (digit) frame <= (frame == 4'(`FRAME_PATTERN_LEN - 1)) ? 4'h0 : frame + 4'h1;
			end
		end
	end

	// Panel code to duty: code 1 and 2 give 2/256, 0 off
	assign panel_duty = (panel_brightness == 8'h01) ? 8'h02 : panel_brightness;

	////////////////////////////////////////////////////////////////
	// Per-digit PWM

	pwm_if dig_if[2] ();
	logic [1:0] gates;

	for (genvar g = 0; g < 2; g++) begin : g_digit
		assign dig_if[g].panel_duty = panel_duty;
		assign dig_if[g].digit_code = (g == 0) ? digit0_intensity : digit1_intensity;
		assign dig_if[g].step       = step;
		assign dig_if[g].frame      = frame;
		assign dig_if[g].level      = (g == 0) ? pixel_level0_in : pixel_level1_in;
		assign dig_if[g].two_bit    = plane_depth_select;
		assign dig_if[g].geometric  = pixel_scale[g];
		assign gates[g]             = dig_if[g].gate;
		digit_pwm u_pwm (
			.p (dig_if[g])
		);
	end

	// Registered drive outputs
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			seg_drive_out   <= 1'b0;
			digit_sel_out   <= 1'b0;
			plane_out       <= 2'h0;
			plane_depth_out <= 1'b0;
			display_ptr_out <= `RST_PTR;
		end else begin
			seg_drive_out   <= gates[digit];
			digit_sel_out   <= digit;
			plane_out       <= current_plane;
			plane_depth_out <= plane_depth_select;
			display_ptr_out <= display_ptr;
		end
	end

endmodule // led_matrix_intensity_plane_control
`default_nettype wire

/* common/led_cfg.svh */
`ifndef LED_CFG_SVH
`define LED_CFG_SVH

// Register addresses
`define ADDR_PANEL_BRIGHTNESS   8'h02
`define ADDR_DIGIT0_INTENSITY   8'h03
`define ADDR_DIGIT1_INTENSITY   8'h04
`define ADDR_DRIVER_SELECT      8'h08
`define ADDR_DISPLAY_PTR_LOW    8'h09
`define ADDR_DISPLAY_PTR_HIGH   8'h0a
`define ADDR_PLANE_SEQ_CTRL     8'h0b
`define ADDR_PANEL_CONFIG       8'h0d
`define ADDR_PIXEL_SCALE        8'h0e

// Field positions
`define PANEL_CFG_DEPTH_BIT     7
`define SEQ_FAST_BIT            7
`define SEQ_AUTO_BIT            6
`define SEQ_COUNT_MSB           5
`define PTR_HIGH_MSB            5

// Reset values
`define RST_BYTE                8'h00
`define RST_PTR                 14'h0000
`define RST_GRAD                2'h0

// Timing
`define CLK_PERIOD_NS           8
`define DIGIT_PERIOD_NS         122000
`define PWM_STEPS               256
`define STEP_CYCLES             ((`DIGIT_PERIOD_NS / `CLK_PERIOD_NS) / `PWM_STEPS)
`define BLANK_STEPS             4
`define SECOND_NS               1000000000
`define CYCLES_PER_SECOND       (`SECOND_NS / `CLK_PERIOD_NS)
`define FRAME_PATTERN_LEN       12

`endif

/* common/led_pkg.sv */
package led_pkg;
	typedef enum {SEQ_MANUAL, SEQ_AUTO_SLOW, SEQ_AUTO_FAST} seq_mode_e;
	typedef logic [1:0] plane_t;
	typedef logic [7:0] byte_t;
	typedef logic [1:0] level_t;
endpackage

/* common/pwm_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface pwm_if;
	logic [7:0] panel_duty;
	logic [7:0] digit_code;
	logic [7:0] step;
	logic [3:0] frame;
	logic [1:0] level;
	logic       two_bit;
	logic       geometric;
	logic       gate;
	modport ctrl (output panel_duty, digit_code, step, frame, level, two_bit, geometric, input gate);
	modport digit (input panel_duty, digit_code, step, frame, level, two_bit, geometric, output gate);
endinterface
`default_nettype wire

/* core/digit_pwm.sv */
`timescale 1ns/10ps
`default_nettype none
`include "led_cfg.svh"
module digit_pwm
	import led_pkg::*;
(
	pwm_if.digit p
);
	logic [15:0] product;
	logic [7:0]  duty;
	logic        in_window;
	logic        pwm_on;
	logic        pixel_on;
	logic [1:0]  mod3;
	logic [1:0]  mod4;

	// Digit share of panel duty, then compare with step
	assign product   = p.panel_duty * p.digit_code;
	assign duty      = product[15:8];
	assign in_window = p.step < 8'(`PWM_STEPS - `BLANK_STEPS);
	assign pwm_on    = (p.step < duty) && in_window;
	assign mod3      = 2'(p.frame % 4'd3);
	assign mod4      = p.frame[1:0];

	// Frame modulation of pixel level
	always_comb begin
		pixel_on = 1'b0;
		if (!p.two_bit) begin
			pixel_on = p.level[0];
		end else begin
			unique case (p.level)
				2'h0: pixel_on = 1'b0;
				2'h1: pixel_on = p.geometric ? (mod4 == 2'h1) : (mod3 == 2'h1);
				2'h2: pixel_on = p.geometric ? !p.frame[0] : (mod3 != 2'h1);
				2'h3: pixel_on = 1'b1;
			endcase
		end
	end

	assign p.gate = pwm_on & pixel_on;
endmodule // digit_pwm
`default_nettype wire

/* sim/led_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module led_host_model (
	// Clock and read answer
	input  wire logic       clk_in,
	input  wire logic       rd_valid_in,
	input  wire logic [7:0] rd_data_in,
	// Register strobes
	output logic            wr_en_out,
	output logic      [7:0] wr_addr_out,
	output logic      [7:0] wr_data_out,
	output logic            rd_en_out,
	output logic      [7:0] rd_addr_out
);
	// Idle bus at time zero
	initial begin
		wr_en_out = 1'b0;
		wr_addr_out = 8'h00;
		wr_data_out = 8'h00;
		rd_en_out = 1'b0;
		rd_addr_out = 8'h00;
	end
	// One-cycle write strobe; released lines flip so nothing stale lingers
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_in);
		#1;
		wr_en_out = 1'b1;
		wr_addr_out = a;
		wr_data_out = d;
		@(posedge clk_in);
		#1;
		wr_en_out = 1'b0;
		wr_addr_out = ~a;
		wr_data_out = ~d;
	endtask
	// Read strobe; registered answer is taken in the next cycle, as the strobe drops
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_in);
		#1;
		rd_en_out = 1'b1;
		rd_addr_out = a;
		@(posedge clk_in);
		#1;
		rd_en_out = 1'b0;
		rd_addr_out = ~a;
		d = (rd_valid_in === 1'b1) ? rd_data_in : 8'hxx;
	endtask
endmodule // led_host_model
`default_nettype wire

/* sim/led_matrix_intensity_plane_control_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
module led_matrix_intensity_plane_control_monitor (
	// Clock and reset
	input wire logic        clk_in,
	input wire logic        srst_in,
	// Inputs watched
	input wire logic        four_level_in,
	input wire logic [7:0]  driver_id_in,
	input wire logic        wr_en_in,
	input wire logic [7:0]  wr_addr_in,
	input wire logic [7:0]  wr_data_in,
	input wire logic        rd_en_in,
	input wire logic        data_xfer_in,
	// Outputs watched
	input wire logic        rd_valid_out,
	input wire logic        rd_mine_out,
	input wire logic [13:0] display_ptr_out,
	input wire logic        seg_drive_out,
	input wire logic [1:0]  plane_out,
	input wire logic        plane_depth_out
);
	logic [7:0] sel;
	logic [7:0] pb;
	default clocking @(posedge clk_in); endclocking
	default disable iff (srst_in);
	// Mirror of driver select and panel brightness
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			sel <= 8'h00;
			pb <= 8'h00;
		end else if (wr_en_in && wr_addr_in == 8'h08) begin
			sel <= wr_data_in;
		end else if (wr_en_in && wr_addr_in == 8'h02) begin
			pb <= wr_data_in;
		end
	end
	a_read_answer: assert property (rd_en_in |=> rd_valid_out) else $error("read not answered");
	a_read_cause: assert property (rd_valid_out |-> $past(rd_en_in)) else $error("answer without read");
	a_read_owner: assert property (rd_valid_out |-> rd_mine_out == ($past(sel) == $past(driver_id_in)))
		else $error("wrong owner flag");
	a_depth_strap: assert property (plane_depth_out |-> $past(four_level_in, 2)) else $error("depth set");
	a_ptr_step: assert property (data_xfer_in && !wr_en_in |=> ##1 display_ptr_out == $past(display_ptr_out) + 14'h1)
		else $error("pointer did not step");
	a_ptr_hold: assert property (!data_xfer_in && !wr_en_in |=> ##1 $stable(display_ptr_out))
		else $error("pointer moved");
	a_dark_panel: assert property (pb == 8'h00 && $past(pb) == 8'h00 && $past(pb, 3) == 8'h00 |-> !seg_drive_out)
		else $error("lit at zero brightness");
	a_manual_plane: assert property (wr_en_in && wr_addr_in == 8'h0b && !wr_data_in[6] && !plane_depth_out
		|=> ##1 plane_out == $past(wr_data_in[1:0], 2)) else $error("manual plane wrong");
	a_auto_start: assert property (wr_en_in && wr_addr_in == 8'h0b && wr_data_in[6] |=> ##1 plane_out == 2'h0)
		else $error("auto not at plane zero");
endmodule // led_matrix_intensity_plane_control_monitor
bind led_matrix_intensity_plane_control led_matrix_intensity_plane_control_monitor mon (.clk_in(clk_in),
	.srst_in(srst_in), .four_level_in(four_level_in), .driver_id_in(driver_id_in), .wr_en_in(wr_en_in),
	.wr_addr_in(wr_addr_in), .wr_data_in(wr_data_in), .rd_en_in(rd_en_in), .data_xfer_in(data_xfer_in),
	.rd_valid_out(rd_valid_out), .rd_mine_out(rd_mine_out), .display_ptr_out(display_ptr_out),
	.seg_drive_out(seg_drive_out), .plane_out(plane_out), .plane_depth_out(plane_depth_out));
`default_nettype wire

/* sim/led_matrix_intensity_plane_control_tb.sv */
`timescale 1ns/10ps
`default_nettype none
`include "led_cfg.svh"
module led_matrix_intensity_plane_control_tb;
	logic        clk_in = 1'b0;
	logic        srst_in = 1'b1;
	logic        four_level_in = 1'b0;
	logic [7:0]  driver_id_in = 8'h5a;
	logic        data_xfer_in = 1'b0;
	logic [1:0]  px0 = 2'h3;
	logic [1:0]  px1 = 2'h3;
	logic        wr_en_in, rd_en_in, rd_valid_out, rd_mine_out, seg_drive_out, plane_depth_out;
	logic        digit_sel_out;
	int          frames = 0;
	// Frame patterns, one bit per frame: geometric 1/4 and arithmetic 2/3
	localparam logic [11:0] geo_quarter      = 12'h222;
	localparam logic [11:0] arith_two_thirds = 12'hb6d;
	logic [7:0]  wr_addr_in, wr_data_in, rd_addr_in, rd_data_out;
	logic [13:0] display_ptr_out;
	logic [1:0]  plane_out;
	int          errors = 0;
	int          checks_done = 0;
	int          cycles = 0;
	led_matrix_intensity_plane_control #(.CYCLES_PER_SECOND(1000)) dut (.clk_in(clk_in), .srst_in(srst_in),
		.four_level_in(four_level_in), .driver_id_in(driver_id_in), .wr_en_in(wr_en_in), .wr_addr_in(wr_addr_in),
		.wr_data_in(wr_data_in), .rd_en_in(rd_en_in), .rd_addr_in(rd_addr_in), .rd_data_out(rd_data_out),
		.rd_valid_out(rd_valid_out), .rd_mine_out(rd_mine_out), .data_xfer_in(data_xfer_in),
		.display_ptr_out(display_ptr_out), .pixel_level0_in(px0), .pixel_level1_in(px1),
		.seg_drive_out(seg_drive_out), .digit_sel_out(digit_sel_out), .plane_out(plane_out),
		.plane_depth_out(plane_depth_out));
	led_host_model host (.clk_in(clk_in), .rd_valid_in(rd_valid_out), .rd_data_in(rd_data_out),
		.wr_en_out(wr_en_in), .wr_addr_out(wr_addr_in), .wr_data_out(wr_data_in), .rd_en_out(rd_en_in),
		.rd_addr_out(rd_addr_in));
	////////////////////////////////////////////////////////////////////////////////
	// Clock and hang guard
	initial begin
		forever #4 clk_in = ~clk_in;
	end
	initial begin
		forever begin
			@(posedge clk_in);
			cycles++;
			if (cycles == 99000) begin
				errors++;
				stop_test();
			end
		end
	end
	// Frame tracker: digit 1 to digit 0 marks a new frame; reset edge ignored
	always @(negedge digit_sel_out) begin
		if (!srst_in) frames <= (frames == `FRAME_PATTERN_LEN - 1) ? 0 : frames + 1;
	end
	task automatic stop_test();
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic cmp_val(input logic [13:0] got, input logic [13:0] exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cmp_cnt(input int got, input int exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask
	task automatic chk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		host.rd(a, d);
		cmp_val({6'h00, d}, {6'h00, e});
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Reset values, read-back, ignored bits and unmapped place
	task automatic t_regs();
		logic [7:0] regs [5];
		regs = '{8'h02, 8'h08, 8'h09, 8'h0a, 8'h0b};
		foreach (regs[i]) chk(regs[i], 8'h00);
		host.wr(8'h02, 8'ha5);
		host.wr(8'h08, 8'hc3);
		host.wr(8'h09, 8'h5a);
		host.wr(8'h0a, 8'hff);
		host.wr(8'h20, 8'h77);
		chk(8'h02, 8'ha5);
		chk(8'h08, 8'hc3);
		chk(8'h09, 8'h5a);
		chk(8'h0a, 8'h3f);
		chk(8'h20, 8'h00);
	endtask
	// Owner flag follows the select loaded beforehand
	task automatic t_owner();
		host.wr(8'h08, 8'h5a);
		chk(8'h08, 8'h5a);
		cmp_val({13'h0, rd_mine_out}, 14'h1);
		host.wr(8'hff, 8'hff);
		host.wr(8'h08, 8'h5b);
		chk(8'h08, 8'h5b);
		cmp_val({13'h0, rd_mine_out}, 14'h0);
	endtask
	// Pointer wraps from the top address
	task automatic t_ptr();
		host.wr(8'h09, 8'hff);
		host.wr(8'h0a, 8'h3f);
		step(2);
		cmp_val(display_ptr_out, 14'h3fff);
		data_xfer_in = 1'b1;
		step(1);
		data_xfer_in = 1'b0;
		step(1);
		cmp_val(display_ptr_out, 14'h0000);
	endtask
	// Depth strap, then manual plane in each depth
	task automatic t_depth();
		host.wr(8'h0d, 8'h80);
		chk(8'h0d, 8'h00);
		four_level_in = 1'b1;
		host.wr(8'h0d, 8'h80);
		step(1);
		cmp_val({13'h0, plane_depth_out}, 14'h1);
		host.wr(8'h0b, 8'h03);
		step(1);
		cmp_val({12'h0, plane_out}, 14'h1);
		host.wr(8'h0d, 8'h00);
		step(2);
		host.wr(8'h0b, 8'h02);
		step(1);
		cmp_val({12'h0, plane_out}, 14'h2);
	endtask
	// Slow and fast sequencing with wrap
	task automatic t_auto();
		host.wr(8'h0b, 8'h41);
		step(500);
		cmp_val({12'h0, plane_out}, 14'h0);
		step(1000);
		cmp_val({12'h0, plane_out}, 14'h1);
		host.wr(8'h0b, 8'hc4);
		step(125);
		cmp_val({12'h0, plane_out}, 14'h0);
		step(750);
		cmp_val({12'h0, plane_out}, 14'h3);
		step(250);
		cmp_val({12'h0, plane_out}, 14'h0);
		host.wr(8'h0b, 8'h00);
	endtask
	// Lit cycles over one period of both digits
	task automatic t_duty(input logic [7:0] p, input logic [7:0] d0, input logic [7:0] d1, input int lit);
		int n;
		n = 0;
		host.wr(8'h02, p);
		host.wr(8'h03, d0);
		host.wr(8'h04, d1);
		step(8);
		repeat (2 * 256 * `STEP_CYCLES) begin
			@(posedge clk_in);
			#1;
			if (seg_drive_out === 1'b1) n++;
		end
		cmp_cnt(n, lit * `STEP_CYCLES);
	endtask
	// Two-bit levels, per-digit graduation, minimum panel code over one aligned frame
	task automatic t_levels();
		int n;
		int h;
		int e;
		n = 0;
		h = 0;
		host.wr(8'h0d, 8'h80);
		host.wr(8'h0e, 8'h01);
		host.wr(8'h02, 8'h01);
		host.wr(8'h04, 8'hff);
		chk(8'h0d, 8'h80);
		chk(8'h0e, 8'h01);
		px0 = 2'h1;
		px1 = 2'h2;
		@(negedge digit_sel_out);
		#1;
		e = `STEP_CYCLES * (int'(geo_quarter[frames]) + int'(arith_two_thirds[frames]));
		repeat (2 * 256 * `STEP_CYCLES) begin
			if (seg_drive_out === 1'b1) n++;
			if (digit_sel_out === 1'b1) h++;
			@(posedge clk_in);
			#1;
		end
		cmp_cnt(n, e);
		cmp_cnt(h, 256 * `STEP_CYCLES);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		step(16);
		srst_in = 1'b0;
		t_regs();
		t_owner();
		t_ptr();
		t_depth();
		t_auto();
		t_duty(8'hff, 8'hff, 8'h80, 252 + 127);
		t_levels();
		stop_test();
	end
endmodule // led_matrix_intensity_plane_control_tb
`default_nettype wire
